// ---- design/status_indicator_defines.svh ----
/*
 * Constants for the network indicator and relay logic: flash timing,
 * clock rate and counter sizes.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef STATUS_INDICATOR_DEFINES_SVH
`define STATUS_INDICATOR_DEFINES_SVH

// System clock rate in Hz
`define SYS_CLOCK_HZ 200000000
// Half flash period (on time, equal to off time) in milliseconds
`define NET_FLASH_HALF_MS 500
// Half flash period in clock cycles
`define NET_FLASH_HALF_CYCLES ((`SYS_CLOCK_HZ / 1000) * `NET_FLASH_HALF_MS)
// Width of the timed-out owner connection counter
`define EO_COUNT_WIDTH 4
// Reset value of the relay drive: contact open
`define RELAY_RESET 1'b0

`endif

// ---- design/status_indicator_pkg.sv ----
/*
 * Types shared by the indicator logic: the charge state code from the
 * charge controller and the states of the network indicator.
 * Assumes nothing of its surroundings.
 */
package status_indicator_pkg;

    typedef enum logic [2:0] {
        chg_none,
        chg_charging,
        chg_charged,
        chg_discharging,
        chg_discharged
    } charge_state_e;

    typedef enum logic [2:0] {
        net_off,
        net_flash_green,
        net_steady_green,
        net_flash_red,
        net_steady_red
    } net_state_e;

endpackage : status_indicator_pkg

// ---- design/flash_if.sv ----
/*
 * Link between the indicator state machine and the flash generator.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface flash_if;
    logic restart;
    logic phase;
    modport ctrl (output restart, input phase);
    modport gen  (input restart, output phase);
endinterface : flash_if

`default_nettype wire

// ---- design/flash_gen.sv ----
/*
 * Common flash timebase: phase is high for HALF_CYCLES cycles, then low
 * for HALF_CYCLES cycles; a restart starts a fresh on half.
 * Assumes one clock, an asynchronous active-high reset and a clock enable.
 */
`timescale 1ns/1ps
`default_nettype none

module flash_gen #(
    parameter int unsigned HALF_CYCLES = 100000000
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic clk_en,
    // Flash phase to the state machine
    flash_if.gen      fl
);
    localparam int unsigned CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
    localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

    if (HALF_CYCLES < 1) begin : g_bad_half
        $error("flash_gen: HALF_CYCLES must be at least 1");
    end

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          phase_q;
    logic          phase_d;

    always_comb begin
        cnt_d   = cnt_q;
        phase_d = phase_q;
        if (fl.restart) begin
            cnt_d   = '0;
            phase_d = 1'b1;
        end else if (cnt_q == LAST) begin
            cnt_d   = '0;
            phase_d = ~phase_q;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q   <= '0;
            phase_q <= 1'b1;
        end else if (clk_en) begin
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
        end
    end

    assign fl.phase = phase_q;

    a_flash_restart_on: assert property (@(posedge clock) disable iff (rst)
        (clk_en && fl.restart) |=> (phase_q && cnt_q == '0))
        else $error("flash restart did not start an on half");

    a_flash_half_turn: assert property (@(posedge clock) disable iff (rst)
        (clk_en && !fl.restart && cnt_q == LAST) |=> (phase_q != $past(phase_q)))
        else $error("flash phase did not turn after a half period");

endmodule : flash_gen

`default_nettype wire

// ---- design/status_indicator_relay.sv ----
/*
 * Network status indicator and relay contact drive of a DC backup supply.
 * Assumes status flags from the network stack and the charge controller
 * are synchronous to clock; event inputs are one-cycle pulses.
 */
// Notes on behaviour
// - Relay output is one normally-open contact, open whenever drive is low.
// - Drive relay when input power present or stored energy feeds output.
// - Relay on while charging, charged, discharging; off when discharged or dead.
// - Indicator dark when unpowered or no IP address configured.
// - IP set, no connections, no owner timeout: flash green.
// - Any connection established, no owner timeout: steady green.
// - Target exclusive-owner connection timeout: flash red.
// - Leave flash red only once all timed-out owner links return; the code counts at most EO_MAX lost links and saturates there.
// - Single-owner device goes steady green on next owner connection.
// - Timeouts of other connection types never cause flash red.
// - Originated or routed connection timeouts never cause flash red.
// - Duplicate IP detected (when supported): steady red.
`timescale 1ns/1ps
`default_nettype none

`include "status_indicator_defines.svh"

module status_indicator_relay #(
    parameter int unsigned FLASH_HALF_CYCLES = `NET_FLASH_HALF_CYCLES,
    parameter int unsigned EO_WIDTH          = `EO_COUNT_WIDTH,
    parameter bit          SINGLE_EO         = 1'b0
) (
    // Clock, reset and enable
    input  wire logic                               clock,
    input  wire logic                               rst,
    input  wire logic                               clk_en,
    // Power and charge controller status
    input  wire logic                               unit_powered,
    input  wire logic                               input_power_present,
    input  wire logic                               output_power_present,
    input  wire status_indicator_pkg::charge_state_e charge_state,
    // Network stack status levels
    input  wire logic                               ip_configured,
    input  wire logic                               conn_established,
    input  wire logic                               dup_ip_supported,
    input  wire logic                               dup_ip_detected,
    // Connection timeout event
    input  wire logic                               timeout_evt,
    input  wire logic                               timeout_is_eo,
    input  wire logic                               timeout_is_target,
    // Connection establish event
    input  wire logic                               establish_evt,
    input  wire logic                               establish_is_eo,
    // Indicator and relay outputs
    output logic                                    net_led_green,
    output logic                                    net_led_red,
    output logic                                    relay_contact_output
);
    localparam logic [EO_WIDTH-1:0] EO_MAX = {EO_WIDTH{1'b1}};
    localparam logic [EO_WIDTH-1:0] EO_ONE = EO_WIDTH'(1);

    if (EO_WIDTH < 1 || EO_WIDTH > 16) begin : g_bad_width
        $error("status_indicator_relay: EO_WIDTH must be 1 to 16");
    end

    flash_if fl ();

    flash_gen #(
        .HALF_CYCLES (FLASH_HALF_CYCLES)
    ) u_flash (
        .clock  (clock),
        .rst    (rst),
        .clk_en (clk_en),
        .fl     (fl)
    );

    // ------------------------------------------------------------------
    // Relay drive
    // ------------------------------------------------------------------
    logic relay_q;
    logic relay_d;
    logic power_any;
    logic charge_live;

    always_comb begin
        power_any   = input_power_present || output_power_present;
        charge_live = 1'b0;
        case (charge_state)
            status_indicator_pkg::chg_charging:    charge_live = 1'b1;
            status_indicator_pkg::chg_charged:     charge_live = 1'b1;
            status_indicator_pkg::chg_discharging: charge_live = 1'b1;
            status_indicator_pkg::chg_discharged:  charge_live = 1'b0;
            default:                               charge_live = 1'b0;
        endcase
        relay_d = power_any && charge_live;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            relay_q <= `RELAY_RESET;
        end else if (clk_en) begin
            relay_q <= relay_d;
        end
    end

    assign relay_contact_output = relay_q;

    // ------------------------------------------------------------------
    // Timed-out exclusive-owner connections
    // ------------------------------------------------------------------
    logic [EO_WIDTH-1:0] eo_lost_q;
    logic [EO_WIDTH-1:0] eo_lost_d;
    logic                eo_take;
    logic                eo_back;

    always_comb begin
        eo_take   = timeout_evt && timeout_is_eo && timeout_is_target;
        eo_back   = establish_evt && establish_is_eo;
        eo_lost_d = eo_lost_q;
        if (!unit_powered) begin
            eo_lost_d = '0;
        end else if (SINGLE_EO) begin
            if (eo_take) begin
                eo_lost_d = EO_ONE;
            end else if (eo_back) begin
                eo_lost_d = '0;
            end
        end else begin
            if (eo_take && !eo_back) begin
                if (eo_lost_q != EO_MAX) begin
                    eo_lost_d = eo_lost_q + EO_ONE;
                end
            end else if (!eo_take && eo_back) begin
                if (eo_lost_q != '0) begin
                    eo_lost_d = eo_lost_q - EO_ONE;
                end
            end else if (eo_take && eo_back && eo_lost_q == '0) begin
                // Set wins over a coincident return
                eo_lost_d = EO_ONE;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eo_lost_q <= '0;
        end else if (clk_en) begin
            eo_lost_q <= eo_lost_d;
        end
    end

    // ------------------------------------------------------------------
    // Indicator state machine
    // ------------------------------------------------------------------
    status_indicator_pkg::net_state_e net_q;
    status_indicator_pkg::net_state_e net_d;
    logic                             green_q;
    logic                             green_d;
    logic                             red_q;
    logic                             red_d;
    logic                             eo_lost_any;

    always_comb begin
        eo_lost_any = (eo_lost_d != '0);
        if (!unit_powered || !ip_configured) begin
            net_d = status_indicator_pkg::net_off;
        end else if (dup_ip_supported && dup_ip_detected) begin
            net_d = status_indicator_pkg::net_steady_red;
        end else if (eo_lost_any) begin
            net_d = status_indicator_pkg::net_flash_red;
        end else if (conn_established) begin
            net_d = status_indicator_pkg::net_steady_green;
        end else begin
            net_d = status_indicator_pkg::net_flash_green;
        end
        fl.restart = (net_d != net_q);
    end

    always_comb begin
        green_d = 1'b0;
        red_d   = 1'b0;
        case (net_q)
            status_indicator_pkg::net_off: begin
                green_d = 1'b0;
                red_d   = 1'b0;
            end
            status_indicator_pkg::net_flash_green: begin
                green_d = fl.phase;
            end
            status_indicator_pkg::net_steady_green: begin
                green_d = 1'b1;
            end
            status_indicator_pkg::net_flash_red: begin
                red_d = fl.phase;
            end
            status_indicator_pkg::net_steady_red: begin
                red_d = 1'b1;
            end
            default: begin
                green_d = 1'b0;
                red_d   = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            net_q   <= status_indicator_pkg::net_off;
            green_q <= 1'b0;
            red_q   <= 1'b0;
        end else if (clk_en) begin
            net_q   <= net_d;
            green_q <= green_d;
            red_q   <= red_d;
        end
    end

    assign net_led_green = green_q;
    assign net_led_red   = red_q;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_owner_lost;
        clk_en && unit_powered && ip_configured && eo_take
            && !(dup_ip_supported && dup_ip_detected);
    endsequence

    sequence s_red_shown;
        net_q == status_indicator_pkg::net_flash_red;
    endsequence

    a_relay_dead_open: assert property (
        (clk_en && !power_any) |=> !relay_contact_output)
        else $error("relay closed with no power present");

    a_relay_backup_on: assert property (
        (clk_en && !input_power_present && output_power_present
            && charge_state == status_indicator_pkg::chg_discharging)
            |=> relay_contact_output)
        else $error("relay open while supplying from stored energy");

    a_relay_discharged: assert property (
        (clk_en && charge_state == status_indicator_pkg::chg_discharged)
            |=> !relay_contact_output)
        else $error("relay closed while discharged");

    a_dark_no_ip: assert property (
        (clk_en && !ip_configured) ##1 clk_en |=> (!net_led_green && !net_led_red))
        else $error("indicator lit without an IP address");

    a_idle_green: assert property (
        (clk_en && unit_powered && ip_configured && !conn_established
            && eo_lost_d == '0 && !(dup_ip_supported && dup_ip_detected))
            |=> net_q == status_indicator_pkg::net_flash_green)
        else $error("idle indicator not flashing green");

    a_owner_red: assert property (
        s_owner_lost |=> s_red_shown)
        else $error("owner timeout did not select flashing red");

    a_red_holds: assert property (
        (clk_en && !SINGLE_EO && unit_powered && eo_lost_q > EO_ONE
            && !(dup_ip_supported && dup_ip_detected) && ip_configured)
            |=> s_red_shown)
        else $error("left flashing red with owner links still lost");

    a_single_clear: assert property (
        (clk_en && SINGLE_EO && eo_back && !eo_take) |=> eo_lost_q == '0)
        else $error("single owner device kept the timeout after reconnect");

    a_other_ignored: assert property (
        (clk_en && timeout_evt && !(timeout_is_eo && timeout_is_target)
            && !eo_back && eo_lost_q == '0) |=> eo_lost_q == '0)
        else $error("non-owner or non-target timeout counted");

    a_dup_red: assert property (
        (clk_en && unit_powered && ip_configured && dup_ip_supported
            && dup_ip_detected) |=> net_q == status_indicator_pkg::net_steady_red)
        else $error("duplicate address not shown steady red");

    a_green_steady: assert property (
        (clk_en && net_q == status_indicator_pkg::net_steady_green)
            |=> net_led_green && !net_led_red)
        else $error("steady green state not lit green");

endmodule : status_indicator_relay

`default_nettype wire

// ---- verification/status_partner.sv ----
/*
 * Far-side model: network stack flags and charge controller status that
 * feed the indicator and relay block.
 * Assumes it is driven by task calls from the bench, in step with clock.
 */
`timescale 1ns/1ps
`default_nettype none

module status_partner (
    // Clock
    input  wire logic                                 clock,
    // Power and charge controller status
    output var logic                                  unit_powered,
    output var logic                                  input_power_present,
    output var logic                                  output_power_present,
    output var status_indicator_pkg::charge_state_e   charge_state,
    // Network stack levels
    output var logic                                  ip_configured,
    output var logic                                  conn_established,
    output var logic                                  dup_ip_supported,
    output var logic                                  dup_ip_detected,
    // Connection events
    output var logic                                  timeout_evt,
    output var logic                                  timeout_is_eo,
    output var logic                                  timeout_is_target,
    output var logic                                  establish_evt,
    output var logic                                  establish_is_eo
);
    initial begin
        unit_powered         = 1'b0;
        input_power_present  = 1'b0;
        output_power_present = 1'b0;
        charge_state         = status_indicator_pkg::chg_none;
        ip_configured        = 1'b0;
        conn_established     = 1'b0;
        dup_ip_supported     = 1'b0;
        dup_ip_detected      = 1'b0;
        timeout_evt          = 1'b0;
        timeout_is_eo        = 1'b1;
        timeout_is_target    = 1'b1;
        establish_evt        = 1'b0;
        establish_is_eo      = 1'b1;
    end

    task set_net(input logic pwr, input logic ip, input logic conn);
        @(posedge clock);
        unit_powered     <= pwr;
        ip_configured    <= ip;
        conn_established <= conn;
    endtask : set_net

    task set_charge(input logic inp, input logic outp,
                    input status_indicator_pkg::charge_state_e st);
        @(posedge clock);
        input_power_present  <= inp;
        output_power_present <= outp;
        charge_state         <= st;
    endtask : set_charge

    task set_dup(input logic sup, input logic det);
        @(posedge clock);
        dup_ip_supported <= sup;
        dup_ip_detected  <= det;
    endtask : set_dup

    // Qualifiers carry the inverse outside the pulse: they mean nothing then
    task timeout(input logic eo, input logic target);
        @(posedge clock);
        timeout_evt       <= 1'b1;
        timeout_is_eo     <= eo;
        timeout_is_target <= target;
        @(posedge clock);
        timeout_evt       <= 1'b0;
        timeout_is_eo     <= ~eo;
        timeout_is_target <= ~target;
    endtask : timeout

    task establish(input logic eo);
        @(posedge clock);
        establish_evt   <= 1'b1;
        establish_is_eo <= eo;
        @(posedge clock);
        establish_evt   <= 1'b0;
        establish_is_eo <= ~eo;
    endtask : establish
endmodule : status_partner

`default_nettype wire

// ---- verification/tb_top.sv ----
/*
 * Self-checking bench for the network indicator and relay block, with a
 * second instance in single-owner mode fed from the same partner.
 * Assumes a short flash half period so flash patterns fit the run.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHECK(what, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module tb_top;
    localparam int HALF = 4;

    logic clock = 1'b0;
    logic rst   = 1'b1;
    logic en    = 1'b1;
    int   err_total  = 0;
    int   n_compared = 0;
    logic up, inp, outp, ip, conn, dsup, ddet;
    logic tevt, teo, ttgt, eevt, eeo;
    status_indicator_pkg::charge_state_e cst;
    logic green, red, relay, s_green, s_red;

    always #2.5 clock = ~clock;

    status_partner far (.clock(clock), .unit_powered(up),
        .input_power_present(inp), .output_power_present(outp),
        .charge_state(cst), .ip_configured(ip), .conn_established(conn),
        .dup_ip_supported(dsup), .dup_ip_detected(ddet),
        .timeout_evt(tevt), .timeout_is_eo(teo), .timeout_is_target(ttgt),
        .establish_evt(eevt), .establish_is_eo(eeo));

    status_indicator_relay #(.FLASH_HALF_CYCLES(HALF)) dut (
        .clock(clock), .rst(rst), .clk_en(en), .unit_powered(up),
        .input_power_present(inp), .output_power_present(outp),
        .charge_state(cst), .ip_configured(ip), .conn_established(conn),
        .dup_ip_supported(dsup), .dup_ip_detected(ddet),
        .timeout_evt(tevt), .timeout_is_eo(teo), .timeout_is_target(ttgt),
        .establish_evt(eevt), .establish_is_eo(eeo),
        .net_led_green(green), .net_led_red(red),
        .relay_contact_output(relay));

    status_indicator_relay #(.FLASH_HALF_CYCLES(HALF), .SINGLE_EO(1'b1))
        dut_single (
        .clock(clock), .rst(rst), .clk_en(en), .unit_powered(up),
        .input_power_present(inp), .output_power_present(outp),
        .charge_state(cst), .ip_configured(ip), .conn_established(conn),
        .dup_ip_supported(dsup), .dup_ip_detected(ddet),
        .timeout_evt(tevt), .timeout_is_eo(teo), .timeout_is_target(ttgt),
        .establish_evt(eevt), .establish_is_eo(eeo),
        .net_led_green(s_green), .net_led_red(s_red),
        .relay_contact_output());

    task step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step

    // Indicator must hold one colour pair over several cycles
    task check_steady(input logic g, input logic r);
        step(3);
        for (int i = 0; i < 6; i++) begin
            `CHECK("net_led_green", g, green)
            `CHECK("net_led_red", r, red)
            step(1);
        end
    endtask : check_steady

    // Over two full periods the lit colour is on exactly half the time
    task check_flash(input logic want_green);
        int n_g;
        int n_r;
        n_g = 0;
        n_r = 0;
        step(3);
        for (int i = 0; i < 4 * HALF; i++) begin
            // Unknown counts as lit so it can never pass as dark
            if (green !== 1'b0) n_g++;
            if (red !== 1'b0) n_r++;
            step(1);
        end
        `CHECK("green on count", want_green ? 2 * HALF : 0, n_g)
        `CHECK("red on count", want_green ? 0 : 2 * HALF, n_r)
    endtask : check_flash

    task tally_and_finish;
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    localparam int ROWS = 7;
    logic rin [ROWS] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
    logic rout[ROWS] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic rexp[ROWS] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    status_indicator_pkg::charge_state_e rst_tab[ROWS] = '{
        status_indicator_pkg::chg_none, status_indicator_pkg::chg_charging,
        status_indicator_pkg::chg_charged,
        status_indicator_pkg::chg_discharging,
        status_indicator_pkg::chg_discharged,
        status_indicator_pkg::chg_charging, status_indicator_pkg::chg_none};

    initial begin
        step(3);
        `CHECK("relay in reset", 1'b0, relay)
        `CHECK("green in reset", 1'b0, green)
        step(2);
        @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < ROWS; i++) begin
            far.set_charge(rin[i], rout[i], rst_tab[i]);
            step(2);
            `CHECK("relay_contact_output", rexp[i], relay)
        end
        far.set_net(1'b0, 1'b1, 1'b1);
        check_steady(1'b0, 1'b0);
        far.set_net(1'b1, 1'b0, 1'b1);
        check_steady(1'b0, 1'b0);
        far.set_net(1'b1, 1'b1, 1'b0);
        check_flash(1'b1);
        far.set_net(1'b1, 1'b1, 1'b1);
        check_steady(1'b1, 1'b0);
        far.timeout(1'b0, 1'b1);
        far.timeout(1'b1, 1'b0);
        check_steady(1'b1, 1'b0);
        far.timeout(1'b1, 1'b1);
        far.timeout(1'b1, 1'b1);
        check_flash(1'b0);
        far.establish(1'b1);
        check_flash(1'b0);
        `CHECK("single owner green", 1'b1, s_green)
        `CHECK("single owner red", 1'b0, s_red)
        far.establish(1'b1);
        check_steady(1'b1, 1'b0);
        far.set_dup(1'b0, 1'b1);
        check_steady(1'b1, 1'b0);
        far.set_dup(1'b1, 1'b1);
        check_steady(1'b0, 1'b1);
        // Clock enable low must freeze the indicator
        @(posedge clock);
        en <= 1'b0;
        far.set_dup(1'b0, 1'b0);
        check_steady(1'b0, 1'b1);
        @(posedge clock);
        en <= 1'b1;
        check_steady(1'b1, 1'b0);
        step(2);
        tally_and_finish();
    end

    initial begin
        #20000;
        err_total++;
        $display("[FAIL] watchdog expected done seen hang");
        tally_and_finish();
    end
endmodule : tb_top

`default_nettype wire
